/* File: logic/fud_pkg.sv */
// Constants, register map and carrier types for the format unit defect list controller.
// Assumes one 250 MHz clock domain shared by the APB slave and the device byte link.
package fud_pkg;
  localparam logic [7:0] OPCODE_FORMAT = 8'h04;
  localparam int CDB_BYTES = 6;
  localparam int HDR_BYTES = 4;
  localparam int LOGICAL_DESC_BYTES = 4;
  localparam int PHYS_DESC_BYTES = 8;
  // Byte positions in the outgoing frame: command block, then list header
  localparam logic [15:0] POS_OPCODE = 16'h0000;
  localparam logic [15:0] POS_FLAGS = 16'h0001;
  localparam logic [15:0] POS_PATTERN = 16'h0002;
  localparam logic [15:0] POS_ILV_HI = 16'h0003;
  localparam logic [15:0] POS_ILV_LO = 16'h0004;
  localparam logic [15:0] POS_CONTROL = 16'h0005;
  localparam logic [15:0] POS_HDR_RSVD = 16'h0006;
  localparam logic [15:0] POS_HDR_FLAGS = 16'h0007;
  localparam logic [15:0] POS_LEN_HI = 16'h0008;
  localparam logic [15:0] POS_LEN_LO = 16'h0009;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_DESC_DATA = 8'h0c;
  localparam logic [7:0] OFF_DESC_COUNT = 8'h10;
  // Command register bits
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_CLEAR_BIT = 1;
  // Defect list format codes and field positions
  localparam logic [1:0] DLF_UNUSABLE = 2'h3;
  localparam int DLF_PHYS_BIT = 2;
  localparam logic [2:0] OPT_NO_LIST = 3'h3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  typedef struct packed {
    logic [15:0] interleave;
    logic [7:0] pattern;
    logic [1:0] spare;
    logic [2:0] dlf;
    logic [2:0] option;
  } fud_ctrl_t;
  typedef struct packed {
    logic format_data_supplied;
    logic complete_list_replace;
    logic format_options_valid_flag;
    logic disable_primary_list;
    logic provided;
  } fud_opt_t;
  typedef struct packed {
    logic valid;
    logic cdb;
    logic [7:0] data;
  } fud_link_t;
endpackage

/* File: logic/fud_format_host.sv */
// Host controller that builds a FORMAT UNIT command and its defect list and streams them out.
// Assumes a byte link with valid/ready and a done/error pulse back from the drive, APB from software.
`timescale 1ns/1ps
`default_nettype none

module fud_format_host #(
  parameter int DESC_WORDS = 16
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output fud_pkg::fud_link_t link_out,
  input wire logic link_ready_in,
  input wire logic link_done_in,
  input wire logic link_error_in
);
  localparam int IW = $clog2(DESC_WORDS);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SEND = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_DONE = 4'b1000
  } fud_state_t;

  // Sending or waiting for the drive; no register may change under a frame
  function automatic logic is_busy(input fud_state_t s);
    return (s == ST_SEND) || (s == ST_WAIT);
  endfunction

  // Option code 0..7 selects formatting choices 1..8; unlisted flags stay zero
  function automatic fud_pkg::fud_opt_t decode_option(input logic [2:0] opt);
    fud_pkg::fud_opt_t o;
    o = '0;
    case (opt)
      3'h0: begin
        // No defects managed
        o.format_data_supplied = 1'b1;
        o.complete_list_replace = 1'b1;
        o.format_options_valid_flag = 1'b1;
        o.disable_primary_list = 1'b1;
      end
      3'h1: begin
        // Factory defects only
        o.format_data_supplied = 1'b1;
        o.complete_list_replace = 1'b1;
      end
      3'h2: begin
        // Grown defects only
        o.format_data_supplied = 1'b1;
        o.format_options_valid_flag = 1'b1;
        o.disable_primary_list = 1'b1;
      end
      fud_pkg::OPT_NO_LIST: begin
        // Factory plus grown: command only, no data-out phase
        o.format_data_supplied = 1'b0;
      end
      3'h4: begin
        // Provided defects only
        o.format_data_supplied = 1'b1;
        o.complete_list_replace = 1'b1;
        o.format_options_valid_flag = 1'b1;
        o.disable_primary_list = 1'b1;
        o.provided = 1'b1;
      end
      3'h5: begin
        // Provided plus factory
        o.format_data_supplied = 1'b1;
        o.complete_list_replace = 1'b1;
        o.provided = 1'b1;
      end
      3'h6: begin
        // Provided plus grown
        o.format_data_supplied = 1'b1;
        o.format_options_valid_flag = 1'b1;
        o.disable_primary_list = 1'b1;
        o.provided = 1'b1;
      end
      default: begin
        // Provided plus existing, header flags zero
        o.format_data_supplied = 1'b1;
        o.provided = 1'b1;
      end
    endcase
    return o;
  endfunction

  // Descriptor length in bytes for a list format
  function automatic logic [15:0] desc_size(input logic [2:0] dlf);
    if (dlf[fud_pkg::DLF_PHYS_BIT]) begin
      return 16'(fud_pkg::PHYS_DESC_BYTES);
    end
    return 16'(fud_pkg::LOGICAL_DESC_BYTES);
  endfunction

  // Byte lane of a stored word, most significant first
  function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [1:0] lane);
    logic [7:0] b;
    case (lane)
      2'h0: b = w[31:24];
      2'h1: b = w[23:16];
      2'h2: b = w[15:8];
      default: b = w[7:0];
    endcase
    return b;
  endfunction

  // Unmapped offsets answer with an error instead of being ignored
  function automatic logic is_mapped(input logic [7:0] a);
    logic hit;
    case (a)
      fud_pkg::OFF_CTRL,
      fud_pkg::OFF_CMD,
      fud_pkg::OFF_STATUS,
      fud_pkg::OFF_DESC_DATA,
      fud_pkg::OFF_DESC_COUNT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  fud_state_t state_reg;
  fud_pkg::fud_ctrl_t ctrl_reg;
  logic [31:0] mem_reg [DESC_WORDS];
  logic [IW:0] wptr_reg;
  logic [7:0] count_reg;
  logic [15:0] pos_reg;
  logic [15:0] len_reg;
  logic [15:0] total_reg;
  logic done_reg;
  logic reject_reg;
  logic error_reg;
  fud_pkg::fud_opt_t opt_reg;

  logic apb_fire;
  logic apb_wr;
  logic addr_ok;
  logic go;
  logic start_ok;
  logic adv;
  logic [15:0] len_next;
  logic [15:0] words_next;
  logic [7:0] byte_next;
  logic [15:0] dpos;
  fud_pkg::fud_opt_t opt_next;

  assign apb_fire = psel_in & penable_in & pready_out;
  assign apb_wr = apb_fire & pwrite_in;
  assign addr_ok = is_mapped(paddr_in);
  assign go = apb_wr && (paddr_in == fud_pkg::OFF_CMD) && pwdata_in[fud_pkg::CMD_GO_BIT] &&
              !is_busy(state_reg);
  assign opt_next = decode_option(ctrl_reg.option);
  assign len_next = opt_next.provided ? 16'(count_reg * desc_size(ctrl_reg.dlf)) : 16'h0000;
  assign words_next = len_next >> 2;
  // Unusable list format with a data-out phase, or more words than stored, is never sent
  assign start_ok = ((ctrl_reg.dlf[2:1] != fud_pkg::DLF_UNUSABLE) ||
                     !opt_next.format_data_supplied) &&
                    (words_next <= 16'(wptr_reg));
  // The next byte loads when the link slot is empty or is being taken
  assign adv = (state_reg == ST_SEND) && (!link_out.valid || link_ready_in);
  assign dpos = pos_reg - 16'(fud_pkg::CDB_BYTES + fud_pkg::HDR_BYTES);

  always_comb begin
    byte_next = 8'h00;
    case (pos_reg)
      fud_pkg::POS_OPCODE: byte_next = fud_pkg::OPCODE_FORMAT;
      fud_pkg::POS_FLAGS: byte_next = {3'h0, opt_reg.format_data_supplied,
                          opt_reg.complete_list_replace, ctrl_reg.dlf};
      fud_pkg::POS_PATTERN: byte_next = ctrl_reg.pattern;
      fud_pkg::POS_ILV_HI: byte_next = ctrl_reg.interleave[15:8];
      fud_pkg::POS_ILV_LO: byte_next = ctrl_reg.interleave[7:0];
      fud_pkg::POS_CONTROL: byte_next = 8'h00;
      fud_pkg::POS_HDR_RSVD: byte_next = 8'h00;
      // Certification and stop-format always zero
      fud_pkg::POS_HDR_FLAGS: byte_next = {opt_reg.format_options_valid_flag,
                                           opt_reg.disable_primary_list, 6'h00};
      fud_pkg::POS_LEN_HI: byte_next = len_reg[15:8];
      fud_pkg::POS_LEN_LO: byte_next = len_reg[7:0];
      default: begin
        // Descriptors go most significant byte first
        byte_next = word_byte(mem_reg[dpos[IW+1:2]], dpos[1:0]);
      end
    endcase
  end

  // APB handshake: one wait state, so a request ends at the second access edge
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out & ~addr_ok;
    end
  end

  // Read data stands only in the ready cycle, zero otherwise
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prdata_out <= 32'h0000_0000;
    end else begin
      prdata_out <= 32'h0000_0000;
      if (psel_in && penable_in && !pready_out && !pwrite_in) begin
        case (paddr_in)
          fud_pkg::OFF_CTRL: prdata_out <= ctrl_reg;
          fud_pkg::OFF_STATUS: prdata_out <= {16'(wptr_reg), 12'h000, error_reg, reject_reg,
                                              done_reg, state_reg != ST_IDLE && !done_reg};
          fud_pkg::OFF_DESC_COUNT: prdata_out <= {24'h000000, count_reg};
          default: prdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Configuration registers; frozen while a command is in flight
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_reg <= fud_pkg::CTRL_RESET;
      count_reg <= 8'h00;
    end else if (apb_wr && !is_busy(state_reg)) begin
      if (paddr_in == fud_pkg::OFF_CTRL) begin
        ctrl_reg <= pwdata_in;
      end
      if (paddr_in == fud_pkg::OFF_DESC_COUNT) begin
        count_reg <= pwdata_in[7:0];
      end
    end
  end

  // Descriptor store; words beyond the depth are dropped
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wptr_reg <= '0;
      for (int i = 0; i < DESC_WORDS; i++) begin
        mem_reg[i] <= 32'h0000_0000;
      end
    end else if (apb_wr && !is_busy(state_reg)) begin
      if (paddr_in == fud_pkg::OFF_CMD && pwdata_in[fud_pkg::CMD_CLEAR_BIT]) begin
        wptr_reg <= '0;
      end else if (paddr_in == fud_pkg::OFF_DESC_DATA && wptr_reg < (IW+1)'(DESC_WORDS)) begin
        mem_reg[wptr_reg[IW-1:0]] <= pwdata_in;
        wptr_reg <= wptr_reg + 1'b1;
      end
    end
  end

  // Sequencer: command bytes, then header and descriptors only with a list
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= ST_IDLE;
      pos_reg <= 16'h0000;
      len_reg <= 16'h0000;
      total_reg <= 16'h0000;
      opt_reg <= '0;
      done_reg <= 1'b0;
      reject_reg <= 1'b0;
      error_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE, ST_DONE: begin
          if (go) begin
            done_reg <= !start_ok;
            reject_reg <= !start_ok;
            error_reg <= 1'b0;
            opt_reg <= opt_next;
            len_reg <= len_next;
            pos_reg <= 16'h0000;
            total_reg <= opt_next.format_data_supplied ?
                         16'(fud_pkg::CDB_BYTES + fud_pkg::HDR_BYTES) + len_next :
                         16'(fud_pkg::CDB_BYTES);
            state_reg <= start_ok ? ST_SEND : ST_DONE;
          end
        end
        ST_SEND: begin
          if (adv) begin
            if (pos_reg == total_reg) begin
              state_reg <= ST_WAIT;
            end else begin
              pos_reg <= pos_reg + 16'h0001;
            end
          end
        end
        ST_WAIT: begin
          if (link_done_in) begin
            error_reg <= link_error_in;
            done_reg <= 1'b1;
            state_reg <= ST_DONE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Link byte register; held until the drive takes it
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      link_out <= '0;
    end else if (adv) begin
      link_out.valid <= (pos_reg != total_reg);
      link_out.cdb <= (pos_reg < 16'(fud_pkg::CDB_BYTES));
      link_out.data <= (pos_reg != total_reg) ? byte_next : 8'h00;
    end
  end
endmodule // fud_format_host

`default_nettype wire

/* File: tb/fud_format_host_chk.sv */
// Checker for the format host: APB answer timing and link byte order.
// Assumes a bind to fud_format_host, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module fud_format_host_chk (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire fud_pkg::fud_link_t link_out,
  input wire logic link_ready_in,
  input wire logic link_done_in
);
  logic [7:0] idx_reg;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // Byte index in the frame; a gap in valid closes the frame
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) idx_reg <= 8'h00;
    else if (!link_out.valid) idx_reg <= 8'h00;
    else if (link_ready_in) idx_reg <= idx_reg + 8'h01;
  end
  a_ready_waits: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("pready late");
  a_ready_single: assert property (pready_out |=> !pready_out) else $error("pready held");
  a_err_ready: assert property (pslverr_out |-> pready_out) else $error("lone pslverr");
  a_frame_opens: assert property (
    $rose(link_out.valid) |-> link_out.cdb && link_out.data == fud_pkg::OPCODE_FORMAT)
    else $error("bad first byte");
  a_byte_holds: assert property (
    link_out.valid && !link_ready_in |=> $stable(link_out)) else $error("byte changed");
  a_cdb_six: assert property (
    link_out.valid |-> link_out.cdb == (idx_reg < 8'h06)) else $error("cdb flag wrong");
  a_lun_zero: assert property (
    link_out.valid && idx_reg == 8'h01 |-> link_out.data[7:5] == 3'h0) else $error("lun");
  a_hdr_zero: assert property (
    link_out.valid && idx_reg == 8'h06 |-> link_out.data == 8'h00) else $error("hdr 0");
  a_hdr_spare: assert property (
    link_out.valid && idx_reg == 8'h07 |-> link_out.data[5:0] == 6'h00) else $error("hdr 1");
  a_quiet_done: assert property (link_done_in |-> !link_out.valid)
    else $error("bytes after end");
endmodule // fud_format_host_chk
bind fud_format_host fud_format_host_chk u_chk (.clock_in, .resetn_in, .psel_in, .penable_in,
  .pready_out, .pslverr_out, .link_out, .link_ready_in, .link_done_in);
`default_nettype wire

/* File: tb/fud_drive_model.sv */
// Drive model: takes link bytes and ends each command with a done pulse.
// Assumes one command at a time; fail_in marks the next command as failed.
`timescale 1ns/1ps
`default_nettype none
module fud_drive_model (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic slow_in,
  input wire logic fail_in,
  input wire fud_pkg::fud_link_t link_in,
  output logic ready_out,
  output logic done_out,
  output logic error_out
);
  logic [7:0] rx_reg [0:255];
  logic [7:0] n_reg;
  logic [7:0] frame_reg;
  logic tog_reg;
  logic last;
  logic [15:0] len;
  // Slow mode takes every other cycle so the host must hold each byte
  assign ready_out = !slow_in || tog_reg;
  // Frame ends after the command, or after header plus length bytes
  assign len = {rx_reg[8], (n_reg == 8'h09) ? link_in.data : rx_reg[9]};
  assign last = link_in.valid && ready_out && ((n_reg == 8'h05 && !rx_reg[1][4])
    || (n_reg >= 8'h09 && {8'h00, n_reg} == len + 16'h0009));
  // Bytes kept verbatim in arrival order; the frame length is latched at the last byte
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      n_reg <= 8'h00;
      tog_reg <= 1'b0;
      done_out <= 1'b0;
      error_out <= 1'b0;
      frame_reg <= 8'h00;
    end else begin
      tog_reg <= !tog_reg;
      done_out <= last;
      error_out <= last && fail_in;
      if (link_in.valid && ready_out) begin
        rx_reg[n_reg] <= link_in.data;
        n_reg <= last ? 8'h00 : n_reg + 8'h01;
      end
      if (last) frame_reg <= n_reg + 8'h01;
    end
  end
endmodule // fud_drive_model
`default_nettype wire

/* File: tb/test_fud_format_host.sv */
// Bench for the format host: APB calls run all eight options and refusals.
// Assumes the drive model answers each frame with a done pulse.
`timescale 1ns/1ps
`default_nettype none
module test_fud_format_host;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, rdy, done, err;
  logic slow = 1'b0;
  logic fail = 1'b0;
  fud_pkg::fud_link_t link;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int k;
  initial forever #2 clock_in = ~clock_in;
  fud_format_host #(.DESC_WORDS(4)) u_fud_format_host (.clock_in, .resetn_in,
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .link_out(link), .link_ready_in(rdy), .link_done_in(done), .link_error_in(err));
  fud_drive_model u_fud_drive_model (.clock_in, .resetn_in, .slow_in(slow), .fail_in(fail),
    .link_in(link), .ready_out(rdy), .done_out(done), .error_out(err));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Whole command plus header fit 80 bits
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    do @(posedge clock_in); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // st is the expected {link error, rejected, done}
  task automatic run(input logic [2:0] o, input logic [2:0] dlf, input logic [7:0] cnt,
    input logic [2:0] st);
    logic [31:0] c, wd;
    logic [15:0] len;
    logic [79:0] g, m;
    logic [7:0] f0;
    int i;
    c = {16'h1234 + 16'(o), 8'ha0 + 8'(o), 2'h0, dlf, o};
    len = (o > 3'h3) ? (16'(cnt) << (dlf[2] ? 3 : 2)) : 16'h0;
    m = (o == 3'h3) ? {8'hff, 8'hf7, 32'hffff_ffff, 32'h0} : {80{1'b1}};
    f0 = u_fud_drive_model.frame_reg;
    slow <= o[0];
    fail <= st[2];
    apb(1'b1, fud_pkg::OFF_CTRL, c);
    apb(1'b1, fud_pkg::OFF_DESC_COUNT, {24'h0, cnt});
    apb(1'b0, fud_pkg::OFF_CTRL, 32'h0);
    chk(80'(q), 80'(c));
    apb(1'b0, fud_pkg::OFF_DESC_COUNT, 32'h0);
    chk(80'(q), 80'(cnt));
    apb(1'b1, fud_pkg::OFF_CMD, 32'h1);
    for (i = 0; i < 100 && q[1] !== 1'b1; i++) apb(1'b0, fud_pkg::OFF_STATUS, 32'h0);
    chk(80'(q[3:1]), 80'(st));
    if (st[1]) chk(80'(u_fud_drive_model.frame_reg), 80'(f0));
    else begin
      chk(80'(u_fud_drive_model.frame_reg), (o == 3'h3) ? 80'h6 : 80'(len) + 80'ha);
      g = 80'h0;
      for (i = 0; i < 10; i++) g = {g[71:0], u_fud_drive_model.rx_reg[i]};
      chk(g & m, {8'h04, 3'h0, o != 3'h3, !o[1], dlf, c[15:8], c[31:16], 8'h00, 8'h00,
        !o[0], !o[0], 6'h00, len} & m);
      for (i = 0; i < len; i++) begin
        wd = 32'hc0de_0a00 + 32'(i / 4);
        chk(80'(u_fud_drive_model.rx_reg[10 + i]), 80'(wd[31 - 8 * (i % 4) -: 8]));
      end
    end
    $display("test option %0d format %0d finished", o, dlf);
  endtask
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge clock_in);
    resetn_in <= 1'b1;
    apb(1'b0, fud_pkg::OFF_CTRL, 32'h0);
    chk(80'(q), 80'(fud_pkg::CTRL_RESET));
    apb(1'b0, 8'h40, 32'h0);
    chk(80'(e), 80'h1);
    apb(1'b1, fud_pkg::OFF_CMD, 32'h2);
    for (k = 0; k < 4; k++) apb(1'b1, fud_pkg::OFF_DESC_DATA, 32'hc0de_0a00 + 32'(k));
    apb(1'b0, fud_pkg::OFF_STATUS, 32'h0);
    chk(80'(q[31:16]), 80'h4);
    $display("test registers finished");
    // Option 3 carries a vendor code that must be ignored; 5 and 6 use eight-byte entries
    for (k = 0; k < 8; k++) run(3'(k), (k == 3) ? 3'h6 : (k == 5) ? 3'h4 : (k == 6) ? 3'h5 : 3'h0,
      8'h02, 3'b001);
    run(3'h4, 3'h6, 8'h02, 3'b011);
    run(3'h7, 3'h7, 8'h02, 3'b011);
    run(3'h7, 3'h4, 8'h03, 3'b011);
    run(3'h7, 3'h0, 8'h04, 3'b101);
    print_verdict();
  end
endmodule // test_fud_format_host
`default_nettype wire
